/* File: hdl/region_protect_pkg.sv */
// constants, field layout and carrier types of the region protection checker
// assumes a 32-bit classic Wishbone slave port and a core on the same clock
//
// Behaviour
// RQ1: up to eight regions, each fully programmable
// RQ2: region size power of two, 32 B to 4 GB
// RQ3: software aligns each base to its size
// RQ4: fetch from non-executable region is a violation
// RQ5: no/ro/rw rights, separate privileged and user
// RQ6: eight equal sub-regions, each with disable bit
// RQ7: disabled end sub-regions give unaligned span ends
// RQ8: violation raises memory-management fault when enabled
// RQ9: region enable bit keeps stored configuration intact
// RQ10: attribute readback includes region enable state
// RQ11: software disables region while reprogramming it
// RQ12: privileged default map covers unmatched privileged accesses
// RQ13: no enabled region, no default: accesses fault
// RQ14: option keeps checking inside hard-fault and NMI
// RQ15: software configures regions before global enable
// RQ16: global enable clear: default map, no faults
// RQ17: readable total count of supported regions
// RQ18: sub-region disables only for 256 B or larger
// RQ19: highest-numbered matching region wins
// RQ20: configuration applies from next access, never partially
package region_protect_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_SELECT = 8'h08;
	localparam logic [7:0] OFS_BASE = 8'h0C;
	localparam logic [7:0] OFS_ATTR = 8'h10;
	localparam logic [7:0] OFS_FSTAT = 8'h14;
	localparam logic [7:0] OFS_FADDR = 8'h18;

	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PRIVDEF_BIT = 1;
	localparam int CTRL_FLTCHK_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// attribute register fields
	localparam int ATTR_EN_BIT = 0;
	localparam int ATTR_SIZE_LSB = 1;
	localparam int ATTR_SRD_LSB = 8;
	localparam int ATTR_AP_LSB = 24;
	localparam int ATTR_XN_BIT = 28;
	localparam int BASE_LSB = 5;

	// size field holds log2(bytes) - 1
	localparam logic [4:0] SIZE_MIN = 5'h04;
	localparam logic [4:0] SIZE_SUBRGN_MIN = 5'h07;
	localparam logic [4:0] SIZE_RST = 5'h00;
	localparam int MAX_REGIONS = 8;

	// access permission codes
	localparam logic [2:0] AP_PRW_UNO = 3'h1;
	localparam logic [2:0] AP_PRW_URO = 3'h2;
	localparam logic [2:0] AP_PRW_URW = 3'h3;
	localparam logic [2:0] AP_PRO_UNO = 3'h5;
	localparam logic [2:0] AP_PRO_URO = 3'h6;
	localparam logic [2:0] AP_PRO_URO2 = 3'h7;

	// one stored region
	typedef struct packed {
		logic [26:0] base;
		logic [4:0] size;
		logic enable;
		logic [7:0] srd;
		logic [2:0] ap;
		logic xn;
	} region_type;

	// one access presented by the core
	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic fetch;
		logic priv;
		logic in_handler;
	} access_type;

	// verdict on one access
	typedef struct packed {
		logic valid;
		logic fault;
		logic default_map;
		logic hit;
		logic [2:0] region;
	} result_type;

endpackage

/* File: hdl/region_protect.sv */
// region protection checker with its Wishbone register file
// assumes the core presents accesses on clk_i and samples the verdict one cycle later
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module region_protect #(
	parameter int NUM_REGIONS = region_protect_pkg::MAX_REGIONS
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic cyc_i, // wishbone cycle
	input wire logic stb_i, // wishbone strobe
	input wire logic we_i, // wishbone write
	input wire logic [7:0] adr_i, // byte address
	input wire logic [3:0] sel_i, // byte lanes
	input wire logic [31:0] dat_i, // write data
	output logic [31:0] dat_o, // read data
	output logic ack_o, // wishbone acknowledge
	input wire logic acc_valid_i, // core access present
	input wire region_protect_pkg::access_type acc_i, // access details
	output var region_protect_pkg::result_type chk_o, // verdict, one cycle later
	output logic mm_fault_o // memory-management fault pulse
);

	// elaboration check on region count
	if (NUM_REGIONS < 1 || NUM_REGIONS > region_protect_pkg::MAX_REGIONS) begin : g_bad
		$error("NUM_REGIONS must lie between 1 and 8");
	end

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [2:0] ctrl;
		logic [2:0] sel;
		region_protect_pkg::region_type [NUM_REGIONS-1:0] rgn;
		logic fault_seen;
		logic [31:0] fault_addr;
		region_protect_pkg::result_type res;
	} state_type;

	state_type st;
	state_type next_st;
	logic [NUM_REGIONS-1:0] hit;

	// attribute word of a region, enable state included
	function automatic logic [31:0] attr_image(input region_protect_pkg::region_type r);
		logic [31:0] w;
		w = 32'h0;
		w[region_protect_pkg::ATTR_EN_BIT] = r.enable; // RQ10
		w[region_protect_pkg::ATTR_SIZE_LSB +: 5] = r.size;
		w[region_protect_pkg::ATTR_SRD_LSB +: 8] = r.srd;
		w[region_protect_pkg::ATTR_AP_LSB +: 3] = r.ap;
		w[region_protect_pkg::ATTR_XN_BIT] = r.xn;
		return w;
	endfunction

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] w;
		w = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				w[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return w;
	endfunction

	// rights table, privileged and user apart
	function automatic logic allowed(input logic [2:0] ap, input logic priv, input logic wr);
		logic ok;
		case (ap)
			region_protect_pkg::AP_PRW_UNO: ok = priv; // RQ5
			region_protect_pkg::AP_PRW_URO: ok = priv | ~wr; // RQ5
			region_protect_pkg::AP_PRW_URW: ok = 1'b1;
			region_protect_pkg::AP_PRO_UNO: ok = priv & ~wr;
			region_protect_pkg::AP_PRO_URO: ok = ~wr;
			region_protect_pkg::AP_PRO_URO2: ok = ~wr;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// per-region address match with sub-region holes
	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_match
		logic [32:0] span_mask;
		logic [31:0] diff;
		logic [2:0] sub_idx;
		logic sub_off;
		logic size_ok;
		region_protect_pkg::region_type r;
		assign r = st.rgn[g];
		assign size_ok = r.size >= region_protect_pkg::SIZE_MIN; // RQ2
		// mask keeps the address bits above the region size
		assign span_mask = ~((33'h1 << (6'(r.size) + 6'h01)) - 33'h1); // RQ2
		assign diff = acc_i.addr ^ {r.base, 5'h00};
		// eighth of the region that the address falls into
		assign sub_idx = 3'(acc_i.addr >> (r.size - 5'h02)); // RQ6
		// holes only count from 256 bytes up
		assign sub_off = (r.size >= region_protect_pkg::SIZE_SUBRGN_MIN) & r.srd[sub_idx]; // RQ18 RQ7
		// a disabled region keeps its fields but never matches
		assign hit[g] = r.enable & size_ok & ((diff & span_mask[31:0]) == 32'h0) & ~sub_off; // RQ9
	end

	// next state: bus slave, configuration and access verdict
	always_comb begin
		logic win;
		logic [2:0] wi;
		logic bypass;
		logic privdef;
		logic [31:0] wd;
		region_protect_pkg::region_type cur;
		next_st = st;
		bypass = 1'b0;
		privdef = 1'b0;
		win = 1'b0;
		wi = 3'h0;
		wd = 32'h0;
		cur = st.rgn[st.sel];
		next_st.ack = 1'b0;
		// single-cycle answer, ack drops the cycle after
		if (cyc_i && stb_i && !st.ack) begin
			next_st.ack = 1'b1;
			next_st.rdata = 32'h0;
			case ({adr_i[7:2], 2'b00})
				region_protect_pkg::OFS_CTRL: begin
					next_st.rdata = {29'h0, st.ctrl};
					if (we_i) begin
						wd = merge({29'h0, st.ctrl}, dat_i, sel_i);
						next_st.ctrl = wd[2:0];
					end
				end
				region_protect_pkg::OFS_COUNT: begin
					next_st.rdata = 32'(NUM_REGIONS); // RQ17
				end
				region_protect_pkg::OFS_SELECT: begin
					next_st.rdata = {29'h0, st.sel};
					if (we_i) begin
						wd = merge({29'h0, st.sel}, dat_i, sel_i);
						if (32'(wd[2:0]) < NUM_REGIONS) begin
							next_st.sel = wd[2:0];
						end
					end
				end
				region_protect_pkg::OFS_BASE: begin
					next_st.rdata = {cur.base, 5'h00};
					if (we_i) begin
						wd = merge({cur.base, 5'h00}, dat_i, sel_i);
						next_st.rgn[st.sel].base = wd[31:region_protect_pkg::BASE_LSB]; // RQ1
					end
				end
				region_protect_pkg::OFS_ATTR: begin
					next_st.rdata = attr_image(cur); // RQ10
					if (we_i) begin
						wd = merge(attr_image(cur), dat_i, sel_i);
						next_st.rgn[st.sel].enable = wd[region_protect_pkg::ATTR_EN_BIT]; // RQ9
						next_st.rgn[st.sel].size = wd[region_protect_pkg::ATTR_SIZE_LSB +: 5];
						next_st.rgn[st.sel].srd = wd[region_protect_pkg::ATTR_SRD_LSB +: 8];
						next_st.rgn[st.sel].ap = wd[region_protect_pkg::ATTR_AP_LSB +: 3];
						next_st.rgn[st.sel].xn = wd[region_protect_pkg::ATTR_XN_BIT];
					end
				end
				region_protect_pkg::OFS_FSTAT: begin
					next_st.rdata = {31'h0, st.fault_seen};
					if (we_i && sel_i[0] && dat_i[0]) begin
						next_st.fault_seen = 1'b0;
					end
				end
				region_protect_pkg::OFS_FADDR: begin
					next_st.rdata = st.fault_addr;
				end
				default: begin
					next_st.rdata = 32'h0;
				end
			endcase
		end
		// highest-numbered matching region takes precedence
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit[i]) begin
				win = 1'b1; // RQ19
				wi = 3'(i); // RQ19
			end
		end
		cur = st.rgn[wi];
		privdef = st.ctrl[region_protect_pkg::CTRL_PRIVDEF_BIT];
		// global off, or handler without checking, uses the default map
		bypass = ~st.ctrl[region_protect_pkg::CTRL_EN_BIT] | // RQ16
			(acc_i.in_handler & ~st.ctrl[region_protect_pkg::CTRL_FLTCHK_BIT]); // RQ14
		// verdict from registers as they stood at this edge
		next_st.res.valid = acc_valid_i; // RQ20
		next_st.res.hit = acc_valid_i & win;
		next_st.res.region = wi;
		next_st.res.default_map = acc_valid_i &
			(bypass | (~win & acc_i.priv & privdef)); // RQ12
		if (!acc_valid_i || bypass) begin
			next_st.res.fault = 1'b0; // RQ16
		end else if (win) begin
			next_st.res.fault = (acc_i.fetch & cur.xn) | // RQ4
				~allowed(cur.ap, acc_i.priv, acc_i.write); // RQ8
		end else begin
			next_st.res.fault = ~(acc_i.priv & privdef); // RQ13 RQ12
		end
		// sticky fault flag, a new fault beats a clear
		if (next_st.res.fault) begin
			next_st.fault_seen = 1'b1;
			next_st.fault_addr = acc_i.addr;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.ctrl <= region_protect_pkg::CTRL_RST;
			for (int i = 0; i < NUM_REGIONS; i++) begin
				st.rgn[i].size <= region_protect_pkg::SIZE_RST;
			end
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state
	assign dat_o = st.rdata;
	assign ack_o = st.ack;
	assign chk_o = st.res;
	assign mm_fault_o = st.res.fault; // RQ8

endmodule

`default_nettype wire

/* File: test/region_protect_sva.sv */
// checker for the region protection block, bound to its ports
// assumes one clock and a synchronous high reset
`timescale 1ns/1ns
`default_nettype none
module region_protect_sva #(
	parameter int NUM_REGIONS = 8
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // reset
	input wire logic cyc_i, // cycle
	input wire logic stb_i, // strobe
	input wire logic we_i, // write
	input wire logic [7:0] adr_i, // address
	input wire logic [3:0] sel_i, // lanes
	input wire logic [31:0] dat_i, // write data
	input wire logic [31:0] dat_o, // read data
	input wire logic ack_o, // acknowledge
	input wire logic acc_valid_i, // access present
	input wire region_protect_pkg::access_type acc_i, // access
	input wire region_protect_pkg::result_type chk_o, // verdict
	input wire logic mm_fault_o // fault pulse
);
	logic [2:0] ctrl; // shadow of the control register
	// follow control writes at their ack edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= 3'h0;
		end else if (ack_o && we_i && adr_i[7:2] == 6'h00 && sel_i[0]) begin
			ctrl <= dat_i[2:0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_latency: assert property ($rose(stb_i) && cyc_i |=> ack_o) else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
	a_count_value: assert property (ack_o && !we_i && adr_i[7:2] == 6'h01 |-> dat_o == NUM_REGIONS)
		else $error("bad region count");
	a_verdict_slot: assert property (acc_valid_i |=> chk_o.valid) else $error("no verdict");
	a_verdict_idle: assert property (!acc_valid_i |=> !chk_o.valid && !mm_fault_o)
		else $error("verdict without access");
	a_fault_pin: assert property (chk_o.fault |-> mm_fault_o && !chk_o.default_map)
		else $error("fault pin mismatch");
	a_off_default: assert property (acc_valid_i && !ctrl[0] |=> chk_o.default_map && !mm_fault_o)
		else $error("fault while off");
	a_handler_map: assert property (acc_valid_i && acc_i.in_handler && !ctrl[2] |=> !chk_o.fault)
		else $error("handler checked");
	c_fault: cover property (mm_fault_o);
	c_handler: cover property (acc_valid_i && acc_i.in_handler && ctrl[2]);
	c_write: cover property (ack_o && we_i);
endmodule
bind region_protect region_protect_sva #(.NUM_REGIONS(NUM_REGIONS)) i_sva (.clk_i, .rst_i,
	.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .acc_valid_i, .acc_i, .chk_o,
	.mm_fault_o);
`default_nettype wire

/* File: test/core_model.sv */
// core model: one access per call, scrambled bus between accesses
// assumes calls come from the bench on the core clock
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input wire logic clk_i, // core clock
	output logic acc_valid_o, // access present
	output var region_protect_pkg::access_type acc_o // access details
);
	// idle bus at time zero
	initial begin
		acc_valid_o = 1'b0;
		acc_o = '0;
	end
	// one cycle of access, then the inverse pattern on the idle bus
	task automatic go(input logic [31:0] a, input logic [3:0] wfph);
		@(posedge clk_i);
		acc_valid_o <= 1'b1;
		acc_o <= {a, wfph};
		@(posedge clk_i);
		acc_valid_o <= 1'b0;
		acc_o <= ~{a, wfph};
	endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the region protection block
// assumes the checker and core model are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [31:0] AP_OK = 32'h5510F730; // allowed {uw,ur,pw,pr} per code
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cs = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] rd;
	logic [31:0] dat_o;
	logic ack_o;
	logic acc_valid_i;
	logic mm_fault_o;
	region_protect_pkg::access_type acc_i;
	region_protect_pkg::result_type chk_o;
	int failures = 0;
	int check_count = 0;
	// 125 MHz clock
	always #4 clk_i = ~clk_i;
	region_protect i_dut (.clk_i, .rst_i, .cyc_i(cs), .stb_i(cs), .we_i, .adr_i, .sel_i(4'hF),
		.dat_i, .dat_o, .ack_o, .acc_valid_i, .acc_i, .chk_o, .mm_fault_o);
	core_model i_core (.clk_i, .acc_valid_o(acc_valid_i), .acc_o(acc_i));
	task automatic conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one classic cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cs <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
		if (n == 20) failures++;
		rd = dat_o;
		cs <= 1'b0;
	endtask
	task automatic acc(input logic [31:0] a, input logic [3:0] wfph, input logic [1:0] e);
		i_core.go(a, wfph);
		#1;
		check({chk_o.valid, chk_o.fault, chk_o.default_map, mm_fault_o}, {1'b1, e, e[1]});
	endtask
	function automatic logic [31:0] attr(logic en, logic [4:0] s, logic [7:0] sd, logic [2:0] ap,
		logic xn);
		return {3'h0, xn, 1'b0, ap, 8'h00, sd, 2'h0, s, en};
	endfunction
	// reprogram a region with it switched off first
	task automatic rg(input logic [2:0] i, input logic [31:0] b, input logic [31:0] at);
		wb(1, 8'h08, {29'h0, i});
		wb(1, 8'h10, 32'h0);
		wb(1, 8'h0C, b);
		wb(1, 8'h10, at);
	endtask
	task automatic t_regs;
		wb(0, 8'h04, 0);
		check(rd, 32'h8);
		wb(0, 8'h1C, 0);
		check(rd, 32'h0);
		acc(32'h2000_0000, 4'h2, 2'b01);
		check({chk_o.hit, chk_o.region}, 4'h0);
		wb(1, 8'h00, 1);
		acc(32'h2000_0000, 4'h2, 2'b10);
		wb(1, 8'h00, 3);
		acc(32'h2000_0000, 4'h2, 2'b01);
		acc(32'h2000_0000, 4'h0, 2'b10);
		$display("registers and defaults done");
	endtask
	task automatic t_perm;
		wb(1, 8'h00, 0);
		rg(0, 32'h2000_0000, attr(1, 9, 0, 3, 0));
		wb(1, 8'h00, 1);
		for (int ap = 0; ap < 8; ap++) begin
			wb(1, 8'h10, attr(1, 9, 0, ap[2:0], 0));
			for (int k = 0; k < 4; k++) begin
				acc(32'h2000_03FC, {k[0], 1'b0, ~k[1], 1'b0}, {~AP_OK[ap * 4 + k], 1'b0});
			end
		end
		wb(1, 8'h10, attr(1, 9, 0, 3, 1));
		acc(32'h2000_0000, 4'h6, 2'b10);
		acc(32'h2000_0000, 4'h2, 2'b00);
		rg(2, 32'h40, attr(1, 4, 0, 3, 0));
		acc(32'h5C, 4'h0, 2'b00);
		acc(32'h60, 4'h0, 2'b10);
		rg(0, 32'h0, attr(1, 31, 0, 3, 0));
		acc(32'hFFFF_FFFC, 4'h0, 2'b00);
		$display("permissions done");
	endtask
	task automatic t_sub;
		rg(0, 32'h2000_0000, attr(1, 9, 0, 3, 0));
		rg(1, 32'h2000_0000, attr(1, 7, 8'h81, 0, 0));
		acc(32'h2000_0000, 4'h0, 2'b00);
		check({chk_o.hit, chk_o.region}, 4'h8);
		acc(32'h2000_0020, 4'h0, 2'b10);
		check({chk_o.hit, chk_o.region}, 4'h9);
		acc(32'h2000_00C0, 4'h0, 2'b10);
		acc(32'h2000_00E0, 4'h0, 2'b00);
		wb(1, 8'h10, attr(1, 6, 8'hFF, 0, 0));
		acc(32'h2000_0000, 4'h0, 2'b10);
		wb(1, 8'h10, attr(0, 6, 8'hFF, 0, 0));
		acc(32'h2000_0000, 4'h0, 2'b00);
		wb(1, 8'h10, attr(1, 6, 8'hFF, 0, 0));
		wb(0, 8'h10, 0);
		check(rd, attr(1, 6, 8'hFF, 0, 0));
		acc(32'h2000_0000, 4'h0, 2'b10);
		acc(32'h2000_0000, 4'h1, 2'b01);
		wb(1, 8'h00, 5);
		acc(32'h2000_0000, 4'h1, 2'b10);
		$display("sub-regions and handlers done");
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		conclude;
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_perm;
		t_sub;
		conclude;
	end
endmodule
`default_nettype wire
